//--- logic/rcadc_pkg.sv
// Shared constants of the RC-oscillation ratio converter.
package rcadc_pkg;
	// Counter geometry.
	localparam int unsigned RCADC_CNT_W = 24;
	localparam logic [23:0] RCADC_CNT_RST = 24'h000000;
	localparam logic [23:0] RCADC_CNT_MAX = 24'hffffff;
	// Register indices; byte address is four times the index.
	localparam logic [9:0] RCADC_IDX_GATE0 = 10'h000;
	localparam logic [9:0] RCADC_IDX_GATE1 = 10'h001;
	localparam logic [9:0] RCADC_IDX_GATE2 = 10'h002;
	localparam logic [9:0] RCADC_IDX_OSC0 = 10'h004;
	localparam logic [9:0] RCADC_IDX_OSC1 = 10'h005;
	localparam logic [9:0] RCADC_IDX_OSC2 = 10'h006;
	localparam logic [9:0] RCADC_IDX_MODE = 10'h008;
	localparam logic [9:0] RCADC_IDX_CTRL = 10'h009;
	localparam logic [9:0] RCADC_IDX_STAT = 10'h00a;
	// Mode register fields and reset.
	localparam int unsigned RCADC_MODE_OSC_LSB = 0;
	localparam int unsigned RCADC_MODE_SRC_BIT = 4;
	localparam int unsigned RCADC_MODE_TB_LSB = 5;
	localparam logic [7:0] RCADC_MODE_RST = 8'h00;
	// Control and status fields.
	localparam int unsigned RCADC_CTRL_RUN_BIT = 0;
	localparam int unsigned RCADC_CTRL_MON_BIT = 1;
	localparam logic [1:0] RCADC_CTRL_RST = 2'h0;
	localparam int unsigned RCADC_STAT_OVF_GATE_BIT = 0;
	localparam int unsigned RCADC_STAT_OVF_OSC_BIT = 1;
	localparam int unsigned RCADC_STAT_START_BIT = 2;
	// Oscillation mode codes.
	localparam logic [3:0] RCADC_OM_EXT0 = 4'h0;
	localparam logic [3:0] RCADC_OM_LAST_CH0 = 4'h4;
	localparam logic [3:0] RCADC_OM_EXT1 = 4'h7;
	// Time-base select codes.
	localparam logic [2:0] RCADC_TB_LS = 3'h0;
	localparam logic [2:0] RCADC_TB_LS2 = 3'h1;
	localparam logic [2:0] RCADC_TB_HS1 = 3'h2;
	localparam logic [2:0] RCADC_TB_HS2 = 3'h3;
	localparam logic [2:0] RCADC_TB_HS4 = 3'h4;
	localparam logic [2:0] RCADC_TB_HS8 = 3'h5;
	// Oscillator pin positions in the pin vectors.
	localparam int unsigned RCADC_PIN_CH0_REF_RES = 0;
	localparam int unsigned RCADC_PIN_CH0_SNS_RES = 1;
	localparam int unsigned RCADC_PIN_CH0_COMBO = 2;
	localparam int unsigned RCADC_PIN_CH0_REF_CAP = 3;
	localparam int unsigned RCADC_PIN_CH1_REF_RES = 4;
	localparam int unsigned RCADC_PIN_CH1_SNS_RES = 5;
	localparam int unsigned RCADC_PIN_CH1_REF_CAP = 6;
	localparam logic [6:0] RCADC_CH0_PINS = 7'h0f;
	localparam logic [6:0] RCADC_CH1_PINS = 7'h70;
	// Bus responses.
	localparam logic [1:0] RCADC_RESP_OKAY = 2'h0;
	localparam logic [1:0] RCADC_RESP_SLVERR = 2'h2;
endpackage

//--- logic/rcadc_counter.sv
// Byte-loadable 24-bit up-counter with a write shadow for reads during a run.
module rcadc_counter
	import rcadc_pkg::*;
(
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// Control.
	input wire logic inc,
	input wire logic hold_shadow,
	input wire logic [2:0] load_en,
	input wire logic [7:0] load_byte,
	// Results.
	output logic [23:0] count,
	output logic [23:0] read_value,
	output logic wrap
);
	typedef struct packed {
		logic [23:0] cnt;
		logic [23:0] shadow;
	} rcadc_cnt_s;

	rcadc_cnt_s s_ff;
	rcadc_cnt_s nxt_s;

	assign count = s_ff.cnt;
	assign wrap = inc && (s_ff.cnt == RCADC_CNT_MAX);
	assign read_value = hold_shadow ? s_ff.shadow : s_ff.cnt;

	always_comb begin
		nxt_s = s_ff;
		if (inc) begin
			nxt_s.cnt = s_ff.cnt + 24'h000001;
		end
		for (int i = 0; i < 3; i++) begin
			if (load_en[i]) begin
				nxt_s.cnt[i*8 +: 8] = load_byte;
				nxt_s.shadow[i*8 +: 8] = load_byte;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_ff <= '{cnt: RCADC_CNT_RST, shadow: RCADC_CNT_RST};
		end else if (ce) begin
			s_ff <= nxt_s;
		end
	end
endmodule // rcadc_counter

//--- logic/rcadc_core.sv
// Conversion core of the RC-oscillation ratio converter with its AXI4-Lite slave.
// Function
// - 24-bit gate counter counts time-base clock.
// - 24-bit oscillator counter counts selected count clock.
// - Per-counter overflow flags; source bit picks interrupt.
// - Run clear stops oscillators and both counters.
// - Start synchronised to time-base edge: falling edge for LS, count tick for other codes.
// - Gate overflow as reference ends conversion.
// - Oscillator overflow as reference ends conversion.
// - Four-bit mode field selects eight modes.
// - Prohibited modes supply no oscillator clock.
// - Drive only mode's resistor and capacitor pins.
// - External modes count channel input pin.
// - Never run both channel oscillators together.
// - Mode dedicates channel pins during conversion.
// - Monitor output carries oscillation waveform.
// - Counter reads return written value while running.
// - Three-bit field selects time-base clock.
// - Reset clears run bit.
// - Reference counter wraps to zero.
module rcadc_core
	import rcadc_pkg::*;
(
	// Clock, reset and clock enable.
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// AXI4-Lite write address and data.
	input wire logic [11:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response.
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read.
	input wire logic [11:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Clock sources and channel inputs.
	input wire logic low_speed_clock,
	input wire logic high_speed_clock,
	input wire logic ch0_clock_input,
	input wire logic ch1_clock_input,
	input wire logic rc_osc_feedback,
	// Oscillator pins and enables.
	output logic [6:0] osc_pin_out,
	output logic [6:0] osc_pin_oe,
	output logic oscillator_ch0,
	output logic oscillator_ch1,
	// Port ownership, monitor and interrupt.
	output logic ch0_pins_dedicated,
	output logic ch1_pins_dedicated,
	output logic oscillation_monitor_out,
	output logic conversion_irq
);
	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [9:0] aw_idx;
		logic [7:0] wbyte;
		logic wlane0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [7:0] rbyte;
		logic [1:0] rresp;
		logic [7:0] conversion_mode_reg;
		logic conversion_run;
		logic monitor_en;
		logic synced_start;
		logic gate_counter_overflow;
		logic osc_counter_overflow;
		logic irq;
		logic ls_q;
		logic hs_q;
		logic [2:0] presc;
		logic src_q;
		logic [6:0] pin_out;
		logic [6:0] pin_oe;
		logic osc0_en;
		logic osc1_en;
		logic ded0;
		logic ded1;
		logic mon;
	} rcadc_core_s;

	rcadc_core_s s_ff;
	rcadc_core_s nxt_s;

	logic [3:0] osc_mode_select;
	logic irq_source_select;
	logic [2:0] time_base_select;
	logic wr_fire;
	logic [9:0] ar_idx;
	logic ls_rise;
	logic ls_fall;
	logic hs_rise;
	logic tb_tick;
	logic tb_fall;
	logic src_level;
	logic src_rise;
	logic gate_inc;
	logic osc_inc;
	logic gate_wrap;
	logic osc_wrap;
	logic ref_wrap;
	logic [2:0] gate_load;
	logic [2:0] osc_load;
	logic [23:0] gate_cnt;
	logic [23:0] osc_cnt;
	logic [23:0] gate_rd;
	logic [23:0] osc_rd;
	logic osc_mode;

	assign osc_mode_select = s_ff.conversion_mode_reg[RCADC_MODE_OSC_LSB +: 4];
	assign irq_source_select = s_ff.conversion_mode_reg[RCADC_MODE_SRC_BIT];
	assign time_base_select = s_ff.conversion_mode_reg[RCADC_MODE_TB_LSB +: 3];
	assign osc_mode = (osc_mode_select > RCADC_OM_EXT0) && (osc_mode_select < RCADC_OM_EXT1);

	// Bus handshakes.
	assign awready = !s_ff.aw_got && !s_ff.bvalid;
	assign wready = !s_ff.w_got && !s_ff.bvalid;
	assign arready = !s_ff.rvalid;
	assign bvalid = s_ff.bvalid;
	assign bresp = s_ff.bresp;
	assign rvalid = s_ff.rvalid;
	assign rresp = s_ff.rresp;
	assign rdata = {24'h000000, s_ff.rbyte};
	assign wr_fire = s_ff.aw_got && s_ff.w_got && !s_ff.bvalid;
	assign ar_idx = araddr[11:2];

	// Pin side outputs.
	assign osc_pin_out = s_ff.pin_out;
	assign osc_pin_oe = s_ff.pin_oe;
	assign oscillator_ch0 = s_ff.osc0_en;
	assign oscillator_ch1 = s_ff.osc1_en;
	assign ch0_pins_dedicated = s_ff.ded0;
	assign ch1_pins_dedicated = s_ff.ded1;
	assign oscillation_monitor_out = s_ff.mon;
	assign conversion_irq = s_ff.irq;

	// Time-base edges.
	assign ls_rise = low_speed_clock && !s_ff.ls_q;
	assign ls_fall = !low_speed_clock && s_ff.ls_q;
	assign hs_rise = high_speed_clock && !s_ff.hs_q;

	always_comb begin
		tb_tick = 1'b0;
		tb_fall = 1'b0;
		unique case (time_base_select)
			RCADC_TB_LS: begin
				tb_tick = ls_rise;
				tb_fall = ls_fall;
			end
			RCADC_TB_LS2: begin
				tb_tick = ls_rise || ls_fall;
				tb_fall = tb_tick;
			end
			RCADC_TB_HS1: begin
				tb_tick = hs_rise;
				tb_fall = hs_rise;
			end
			RCADC_TB_HS2: begin
				tb_tick = hs_rise && s_ff.presc[0];
				tb_fall = tb_tick;
			end
			RCADC_TB_HS4: begin
				tb_tick = hs_rise && (&s_ff.presc[1:0]);
				tb_fall = tb_tick;
			end
			RCADC_TB_HS8: begin
				tb_tick = hs_rise && (&s_ff.presc);
				tb_fall = tb_tick;
			end
			default: begin
				tb_tick = 1'b0;
				tb_fall = 1'b0;
			end
		endcase
	end

	// Oscillator count clock source.
	always_comb begin
		if (osc_mode_select == RCADC_OM_EXT0) begin
			src_level = ch0_clock_input;
		end else if (osc_mode_select == RCADC_OM_EXT1) begin
			src_level = ch1_clock_input;
		end else if (osc_mode) begin
			src_level = rc_osc_feedback;
		end else begin
			src_level = 1'b0;
		end
	end

	assign src_rise = src_level && !s_ff.src_q;
	assign gate_inc = s_ff.synced_start && tb_tick;
	assign osc_inc = s_ff.synced_start && src_rise;
	assign ref_wrap = irq_source_select ? osc_wrap : gate_wrap;

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			gate_load[i] = wr_fire && s_ff.wlane0 && (s_ff.aw_idx == RCADC_IDX_GATE0 + 10'(i));
			osc_load[i] = wr_fire && s_ff.wlane0 && (s_ff.aw_idx == RCADC_IDX_OSC0 + 10'(i));
		end
	end

	rcadc_counter u_gate (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.inc(gate_inc),
		.hold_shadow(s_ff.conversion_run),
		.load_en(gate_load),
		.load_byte(s_ff.wbyte),
		.count(gate_cnt),
		.read_value(gate_rd),
		.wrap(gate_wrap)
	);

	rcadc_counter u_osc (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.inc(osc_inc),
		.hold_shadow(s_ff.conversion_run),
		.load_en(osc_load),
		.load_byte(s_ff.wbyte),
		.count(osc_cnt),
		.read_value(osc_rd),
		.wrap(osc_wrap)
	);

	// Drives the resistor pin in phase and the capacitor pin in antiphase.
	function automatic logic [13:0] pin_drive(input logic [3:0] om, input logic ph);
		logic [6:0] oe;
		logic [6:0] val;
		oe = 7'h00;
		val = 7'h00;
		unique case (om)
			4'h1: begin
				oe[RCADC_PIN_CH0_REF_RES] = 1'b1;
				oe[RCADC_PIN_CH0_REF_CAP] = 1'b1;
				val[RCADC_PIN_CH0_REF_RES] = ph;
				val[RCADC_PIN_CH0_REF_CAP] = !ph;
			end
			4'h2: begin
				oe[RCADC_PIN_CH0_SNS_RES] = 1'b1;
				oe[RCADC_PIN_CH0_REF_CAP] = 1'b1;
				val[RCADC_PIN_CH0_SNS_RES] = ph;
				val[RCADC_PIN_CH0_REF_CAP] = !ph;
			end
			4'h3: begin
				oe[RCADC_PIN_CH0_COMBO] = 1'b1;
				oe[RCADC_PIN_CH0_REF_CAP] = 1'b1;
				val[RCADC_PIN_CH0_COMBO] = ph;
				val[RCADC_PIN_CH0_REF_CAP] = !ph;
			end
			4'h4: begin
				oe[RCADC_PIN_CH0_REF_RES] = 1'b1;
				oe[RCADC_PIN_CH0_COMBO] = 1'b1;
				val[RCADC_PIN_CH0_REF_RES] = ph;
				val[RCADC_PIN_CH0_COMBO] = !ph;
			end
			4'h5: begin
				oe[RCADC_PIN_CH1_REF_RES] = 1'b1;
				oe[RCADC_PIN_CH1_REF_CAP] = 1'b1;
				val[RCADC_PIN_CH1_REF_RES] = ph;
				val[RCADC_PIN_CH1_REF_CAP] = !ph;
			end
			4'h6: begin
				oe[RCADC_PIN_CH1_SNS_RES] = 1'b1;
				oe[RCADC_PIN_CH1_REF_CAP] = 1'b1;
				val[RCADC_PIN_CH1_SNS_RES] = ph;
				val[RCADC_PIN_CH1_REF_CAP] = !ph;
			end
			default: begin
				oe = 7'h00;
			end
		endcase
		return {oe, val};
	endfunction

	always_comb begin
		nxt_s = s_ff;
		nxt_s.ls_q = low_speed_clock;
		nxt_s.hs_q = high_speed_clock;
		nxt_s.src_q = src_level;
		nxt_s.irq = 1'b0;
		if (hs_rise) begin
			nxt_s.presc = s_ff.presc + 3'h1;
		end
		// Write address and data are taken in either order.
		if (awvalid && awready) begin
			nxt_s.aw_got = 1'b1;
			nxt_s.aw_idx = awaddr[11:2];
		end
		if (wvalid && wready) begin
			nxt_s.w_got = 1'b1;
			nxt_s.wbyte = wdata[7:0];
			nxt_s.wlane0 = wstrb[0];
		end
		if (wr_fire) begin
			nxt_s.aw_got = 1'b0;
			nxt_s.w_got = 1'b0;
			nxt_s.bvalid = 1'b1;
			nxt_s.bresp = RCADC_RESP_OKAY;
			unique case (s_ff.aw_idx)
				RCADC_IDX_GATE0, RCADC_IDX_GATE1, RCADC_IDX_GATE2,
				RCADC_IDX_OSC0, RCADC_IDX_OSC1, RCADC_IDX_OSC2: begin
					nxt_s.bresp = RCADC_RESP_OKAY;
				end
				RCADC_IDX_MODE: begin
					if (s_ff.wlane0) begin
						nxt_s.conversion_mode_reg = s_ff.wbyte;
					end
				end
				RCADC_IDX_CTRL: begin
					if (s_ff.wlane0) begin
						nxt_s.conversion_run = s_ff.wbyte[RCADC_CTRL_RUN_BIT];
						nxt_s.monitor_en = s_ff.wbyte[RCADC_CTRL_MON_BIT];
					end
				end
				RCADC_IDX_STAT: begin
					if (s_ff.wlane0 && s_ff.wbyte[RCADC_STAT_OVF_GATE_BIT]) begin
						nxt_s.gate_counter_overflow = 1'b0;
					end
					if (s_ff.wlane0 && s_ff.wbyte[RCADC_STAT_OVF_OSC_BIT]) begin
						nxt_s.osc_counter_overflow = 1'b0;
					end
				end
				default: begin
					nxt_s.bresp = RCADC_RESP_SLVERR;
				end
			endcase
		end
		if (s_ff.bvalid && bready) begin
			nxt_s.bvalid = 1'b0;
		end
		// Reads; counters show the written value while a conversion runs.
		if (s_ff.rvalid && rready) begin
			nxt_s.rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			nxt_s.rvalid = 1'b1;
			nxt_s.rresp = RCADC_RESP_OKAY;
			nxt_s.rbyte = 8'h00;
			unique case (ar_idx)
				RCADC_IDX_GATE0: nxt_s.rbyte = gate_rd[7:0];
				RCADC_IDX_GATE1: nxt_s.rbyte = gate_rd[15:8];
				RCADC_IDX_GATE2: nxt_s.rbyte = gate_rd[23:16];
				RCADC_IDX_OSC0: nxt_s.rbyte = osc_rd[7:0];
				RCADC_IDX_OSC1: nxt_s.rbyte = osc_rd[15:8];
				RCADC_IDX_OSC2: nxt_s.rbyte = osc_rd[23:16];
				RCADC_IDX_MODE: nxt_s.rbyte = s_ff.conversion_mode_reg;
				RCADC_IDX_CTRL: begin
					nxt_s.rbyte[RCADC_CTRL_RUN_BIT] = s_ff.conversion_run;
					nxt_s.rbyte[RCADC_CTRL_MON_BIT] = s_ff.monitor_en;
				end
				RCADC_IDX_STAT: begin
					nxt_s.rbyte[RCADC_STAT_OVF_GATE_BIT] = s_ff.gate_counter_overflow;
					nxt_s.rbyte[RCADC_STAT_OVF_OSC_BIT] = s_ff.osc_counter_overflow;
					nxt_s.rbyte[RCADC_STAT_START_BIT] = s_ff.synced_start;
				end
				default: nxt_s.rresp = RCADC_RESP_SLVERR;
			endcase
		end
		// Overflow flags; a new overflow wins over a clear.
		if (gate_wrap) begin
			nxt_s.gate_counter_overflow = 1'b1;
		end
		if (osc_wrap) begin
			nxt_s.osc_counter_overflow = 1'b1;
		end
		// The reference overflow ends the conversion and requests service.
		if (ref_wrap) begin
			nxt_s.conversion_run = 1'b0;
			nxt_s.irq = 1'b1;
		end
		nxt_s.synced_start = nxt_s.conversion_run && (s_ff.synced_start || tb_fall);
		nxt_s.osc0_en = nxt_s.synced_start && osc_mode && (osc_mode_select <= RCADC_OM_LAST_CH0);
		nxt_s.osc1_en = nxt_s.synced_start && osc_mode && (osc_mode_select > RCADC_OM_LAST_CH0);
		{nxt_s.pin_oe, nxt_s.pin_out} = nxt_s.synced_start ?
			pin_drive(osc_mode_select, rc_osc_feedback) : 14'h0000;
		nxt_s.ded0 = nxt_s.conversion_run && (osc_mode_select <= RCADC_OM_LAST_CH0);
		nxt_s.ded1 = nxt_s.conversion_run && (osc_mode_select > RCADC_OM_LAST_CH0) &&
			(osc_mode_select <= RCADC_OM_EXT1);
		nxt_s.mon = s_ff.monitor_en && osc_mode && s_ff.synced_start && rc_osc_feedback;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_ff <= '0;
			s_ff.conversion_mode_reg <= RCADC_MODE_RST;
			{s_ff.monitor_en, s_ff.conversion_run} <= RCADC_CTRL_RST;
		end else if (ce) begin
			s_ff <= nxt_s;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn || !ce);

	property p_gate_ref_stop;
		gate_wrap && !irq_source_select |=> !s_ff.conversion_run && !s_ff.synced_start && conversion_irq;
	endproperty
	a_gate_ref_stop: assert property (p_gate_ref_stop) else $error("run not ended");

	property p_osc_ref_stop;
		osc_wrap && irq_source_select |=> !s_ff.conversion_run && conversion_irq ##1 !gate_inc;
	endproperty
	a_osc_ref_stop: assert property (p_osc_ref_stop) else $error("run not ended");

	property p_irq_pulse;
		conversion_irq |=> !conversion_irq;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");

	property p_irq_cause;
		conversion_irq |-> ($past(irq_source_select) && $past(osc_wrap)) ||
			(!$past(irq_source_select) && $past(gate_wrap));
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq without overflow");

	property p_idle_still;
		!s_ff.synced_start && !wr_fire |=> $stable(gate_cnt) && $stable(osc_cnt);
	endproperty
	a_idle_still: assert property (p_idle_still) else $error("count while stopped");

	property p_start_sync;
		$rose(s_ff.synced_start) |-> $past(tb_fall) && s_ff.conversion_run;
	endproperty
	a_start_sync: assert property (p_start_sync) else $error("start off tb fall");

	property p_prohibited;
		osc_mode_select[3] |-> !osc_inc ##1 (osc_pin_oe == 7'h00 || !osc_mode_select[3]);
	endproperty
	a_prohibited: assert property (p_prohibited) else $error("count in bad mode");

	property p_exclusive;
		!((|(osc_pin_oe & RCADC_CH0_PINS)) && (|(osc_pin_oe & RCADC_CH1_PINS))) &&
		!(oscillator_ch0 && oscillator_ch1);
	endproperty
	a_exclusive: assert property (p_exclusive) else $error("both channels active");

	property p_wrap_zero;
		gate_wrap && !wr_fire |=> gate_cnt == RCADC_CNT_RST;
	endproperty
	a_wrap_zero: assert property (p_wrap_zero) else $error("no wrap to zero");

	property p_two_pins;
		osc_pin_oe != 7'h00 |-> $countones(osc_pin_oe) == 2 && (osc_pin_out & osc_pin_oe) != 7'h00;
	endproperty
	a_two_pins: assert property (p_two_pins) else $error("bad pin drive");
endmodule // rcadc_core

//--- tb/rcadc_rc_model.sv
// Behavioural RC network that returns the oscillation phase to the core.
module rcadc_rc_model (
	// Clock.
	input wire logic aclk,
	// Oscillator pin enables from the core.
	input wire logic [6:0] osc_pin_oe,
	// Phase returned to the core.
	output logic rc_osc_feedback
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] div_ff = 2'h0;
	logic phase_ff = 1'b0;
	assign rc_osc_feedback = phase_ff;
	// Oscillates only while some pin drives the network, else rests low.
	always @(posedge aclk) begin
		if (|osc_pin_oe) begin
			div_ff <= (div_ff == 2'h2) ? 2'h0 : div_ff + 2'h1;
			if (div_ff == 2'h2) begin
				phase_ff <= ~phase_ff;
			end
		end else begin
			div_ff <= 2'h0;
			phase_ff <= 1'b0;
		end
	end
endmodule // rcadc_rc_model

//--- tb/tb_rc_oscillation_ratio_adc.sv
// Self-checking testbench of the RC-oscillation ratio converter core.
module tb_rc_oscillation_ratio_adc
	import rcadc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic [3:0] wstrb = 0;
	logic [1:0] bresp, rresp, r;
	logic awready, wready, bvalid, arready, rvalid, fb, ls = 0, hs = 0, in0 = 0, in1 = 0;
	logic [6:0] pin_out, pin_oe, eo;
	logic osc0, osc1, ded0, ded1, mon, irq, seen;
	logic [7:0] d;
	logic [23:0] v;
	logic [3:0] cyc = 0;
	int n_fail = 0, tests_run = 0;
	// Time-base ticks expected in 256 cycles, per time-base code 0 to 5.
	int exp_ticks [6] = '{16, 32, 128, 64, 32, 16};
	always #2 aclk = ~aclk;
	// Time-base and external count clocks.
	always @(posedge aclk) begin
		cyc <= cyc + 4'h1;
		hs <= ~hs;
		in0 <= cyc[0];
		in1 <= ~cyc[0];
		ls <= cyc[3];
	end
	rcadc_core u_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awaddr(awaddr),
		.awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .low_speed_clock(ls),
		.high_speed_clock(hs), .ch0_clock_input(in0), .ch1_clock_input(in1),
		.rc_osc_feedback(fb), .osc_pin_out(pin_out), .osc_pin_oe(pin_oe),
		.oscillator_ch0(osc0), .oscillator_ch1(osc1), .ch0_pins_dedicated(ded0),
		.ch1_pins_dedicated(ded1), .oscillation_monitor_out(mon), .conversion_irq(irq));
	rcadc_rc_model u_rc (.aclk(aclk), .osc_pin_oe(pin_oe), .rc_osc_feedback(fb));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		if (n_fail == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic axw(input logic [9:0] idx, input logic [7:0] dat, output logic [1:0] rs);
		logic a, w;
		a = 0;
		w = 0;
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, dat};
		wstrb <= 4'h1;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(a && w)) begin
			@(posedge aclk);
			if (!a && awready) begin
				a = 1;
				awvalid <= 0;
			end
			if (!w && wready) begin
				w = 1;
				wvalid <= 0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 0;
	endtask
	task automatic axr(input logic [9:0] idx, output logic [7:0] dat, output logic [1:0] rs);
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1;
		rready <= 1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		dat = rdata[7:0];
		rs = rresp;
		rready <= 0;
	endtask
	task automatic wr(input logic [9:0] idx, input logic [7:0] dat);
		axw(idx, dat, r);
		check(r, RCADC_RESP_OKAY);
	endtask
	task automatic setc(input logic [9:0] base, input logic [23:0] val);
		for (int i = 0; i < 3; i++) wr(base + 10'(i), val[8*i+:8]);
	endtask
	task automatic getc(input logic [9:0] base, output logic [23:0] val);
		for (int i = 0; i < 3; i++) axr(base + 10'(i), val[8*i+:8], r);
	endtask
	task automatic wait_end();
		for (int i = 0; i < 4000 && irq !== 1'b1; i++) @(posedge aclk);
		check(irq, 1);
		@(posedge aclk);
		#1 check(irq, 0);
		check(pin_oe, 7'h00);
		axr(RCADC_IDX_CTRL, d, r);
		check(d[0], 0);
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		stop_test();
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		axr(RCADC_IDX_CTRL, d, r);
		check(d, 8'h00);
		axr(RCADC_IDX_MODE, d, r);
		check(d, RCADC_MODE_RST);
		axr(10'h003, d, r);
		check(r, RCADC_RESP_SLVERR);
		axw(10'h00f, 8'h01, r);
		check(r, RCADC_RESP_SLVERR);
		// Gate-referenced conversion with monitor on.
		setc(RCADC_IDX_GATE0, 24'hfffff0);
		setc(RCADC_IDX_OSC0, 24'h000000);
		wr(RCADC_IDX_MODE, 8'h41);
		wr(RCADC_IDX_CTRL, 8'h03);
		axr(RCADC_IDX_STAT, d, r);
		check(d[RCADC_STAT_START_BIT], 1);
		seen = 0;
		repeat (20) @(posedge aclk) seen |= (mon === 1'b1);
		check(seen, 1);
		axr(RCADC_IDX_GATE0, d, r);
		check(d, 8'hf0);
		wait_end();
		getc(RCADC_IDX_GATE0, v);
		check(v, 24'h000000);
		getc(RCADC_IDX_OSC0, v);
		check(v != 0, 1);
		axr(RCADC_IDX_STAT, d, r);
		check(d[RCADC_STAT_OVF_GATE_BIT], 1);
		wr(RCADC_IDX_STAT, 8'h03);
		// Oscillator-referenced conversion.
		setc(RCADC_IDX_OSC0, 24'hfffff8);
		setc(RCADC_IDX_GATE0, 24'h000000);
		wr(RCADC_IDX_MODE, 8'h52);
		wr(RCADC_IDX_CTRL, 8'h01);
		wait_end();
		getc(RCADC_IDX_OSC0, v);
		check(v, 24'h000000);
		getc(RCADC_IDX_GATE0, v);
		check(v != 0, 1);
		axr(RCADC_IDX_STAT, d, r);
		check(d, 8'h02);
		// Oscillator-referenced runs on the external clock, one per time-base code 0 to 5.
		for (int k = 0; k < 6; k++) begin
			setc(RCADC_IDX_OSC0, 24'hffff80);
			setc(RCADC_IDX_GATE0, 24'h000000);
			wr(RCADC_IDX_MODE, {3'(k), 5'h10});
			wr(RCADC_IDX_CTRL, 8'h01);
			wait_end();
			getc(RCADC_IDX_GATE0, v);
			check(v + 2 >= exp_ticks[k] && v <= exp_ticks[k] + 2, 1);
		end
		// A prohibited time base never starts; a reset in mid-run clears the run bit.
		wr(RCADC_IDX_MODE, 8'hd0);
		wr(RCADC_IDX_CTRL, 8'h01);
		repeat (40) @(posedge aclk);
		axr(RCADC_IDX_STAT, d, r);
		check(d[RCADC_STAT_START_BIT], 0);
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		axr(RCADC_IDX_CTRL, d, r);
		check(d, 8'h00);
		axr(RCADC_IDX_MODE, d, r);
		check(d, RCADC_MODE_RST);
		// Every oscillation mode code, prohibited ones included.
		setc(RCADC_IDX_GATE0, 24'h000000);
		for (int m = 0; m < 16; m++) begin
			case (m)
				1: eo = 7'h09;
				2: eo = 7'h0a;
				3: eo = 7'h0c;
				4: eo = 7'h05;
				5: eo = 7'h50;
				6: eo = 7'h60;
				default: eo = 7'h00;
			endcase
			wr(RCADC_IDX_OSC0, 8'h00);
			wr(RCADC_IDX_MODE, 8'h40 | 8'(m));
			wr(RCADC_IDX_CTRL, 8'h01);
			repeat (30) @(posedge aclk);
			#1 check(pin_oe, eo);
			if (eo != 0) check($countones(pin_out & eo), 1);
			check({osc0, osc1}, {m >= 1 && m <= 4, m == 5 || m == 6});
			check({ded0, ded1}, {m <= 4, m >= 5 && m <= 7});
			wr(RCADC_IDX_CTRL, 8'h00);
			axr(RCADC_IDX_OSC0, d, r);
			check(d != 0, m < 8);
		end
		stop_test();
	end
endmodule // tb_rc_oscillation_ratio_adc
